// File: hw/hpf_core.sv
`timescale 1ns/1ps
`default_nettype none
module hpf_core
	import rx_path_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Sample stream
	input wire logic signed [rx_path_pkg::SAMPLE_W-1:0] in_sample,
	output logic signed [rx_path_pkg::SAMPLE_W-1:0] out_sample
);
	localparam logic signed [SAMPLE_W-1:0] MAX_CODE = 10'sh1FF;
	localparam logic signed [SAMPLE_W-1:0] MIN_CODE = -10'sh200;

	logic signed [SAMPLE_W-1:0] prev_in;
	logic signed [ACC_W-1:0] acc;
	wire signed [63:0] x_term;
	wire signed [63:0] z_term;
	wire signed [63:0] p_term;
	wire signed [63:0] sum;
	wire signed [ACC_W-1:0] next_acc;
	wire signed [ACC_W-FRAC_W-1:0] next_int;
	wire signed [SAMPLE_W-1:0] next_out;

	// y = x - z*x' + p*y', all in Q16; wide state keeps the tail quiet
	assign x_term = 64'(in_sample) <<< FRAC_W;
	assign z_term = 64'(prev_in) * $signed({1'b0, ZERO_Q});
	assign p_term = (64'(acc) * $signed({1'b0, POLE_Q})) >>> FRAC_W;
	assign sum = x_term - z_term + p_term;
	assign next_acc = sum[ACC_W-1:0];
	assign next_int = next_acc[ACC_W-1:FRAC_W];
	// Saturate rather than wrap on overload
	assign next_out = (next_int > 16'(MAX_CODE)) ? MAX_CODE :
		(next_int < 16'(MIN_CODE)) ? MIN_CODE :
		next_int[SAMPLE_W-1:0];

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prev_in <= '0;
			acc <= '0;
			out_sample <= '0;
		end
		else
		begin
			prev_in <= in_sample;
			acc <= next_acc;
			out_sample <= next_out;
		end
	end
endmodule
`default_nettype wire

// File: hw/rx_dc_block_and_gain_path.sv
`timescale 1ns/1ps
`default_nettype none
module rx_dc_block_and_gain_path
	import rx_path_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// ADC samples, same clock
	input wire logic [rx_path_pkg::SAMPLE_W-1:0] adc_sample,
	// Register port
	input wire logic [rx_path_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rx_path_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [rx_path_pkg::DATA_W-1:0] reg_rdata,
	// Gain pins from the transmit port, asynchronous
	input wire logic gain_pin,
	input wire logic tx_sync_pin,
	input wire logic [rx_path_pkg::GAIN_W-1:0] tx_gain_pins,
	// Receive samples out
	output logic [rx_path_pkg::SAMPLE_W-1:0] rx_sample,
	// Analog controls
	output logic lpf_bypass,
	output logic lpf_wide,
	output logic [rx_path_pkg::DATA_W-1:0] lpf_tune_target,
	output logic [rx_path_pkg::STAGE_W-1:0] coarse_gain_stage,
	output logic [rx_path_pkg::STAGE_W-1:0] fine_gain_stage,
	output logic [rx_path_pkg::GAIN_W-1:0] sample_gain
);
	import rx_path_pkg::*;

	// Register storage
	logic [DATA_W-1:0] lpf_ctrl;
	logic [DATA_W-1:0] tune_target;
	logic [GAIN_W-1:0] gain_setting;
	logic hpf_bypass;

	// Pin synchronisers
	logic [SYNC_STAGES-1:0] gain_pin_sync;
	logic [SYNC_STAGES-1:0] tx_sync_sync;
	logic [GAIN_W-1:0] gain_val_meta;
	logic [GAIN_W-1:0] gain_val_sync;

	// Pin capture
	pin_state_t pin_state;
	pin_state_t next_pin_state;
	logic [1:0] hold_cnt;
	logic [GAIN_W-1:0] held_val;

	// Gain delay line
	logic [GAIN_W-1:0] gain_pipe [GAIN_LATENCY];

	// Filter path
	wire signed [SAMPLE_W-1:0] filt_sample;

	// Decode
	wire wr_lpf;
	wire wr_tune;
	wire wr_gain;
	wire wr_hpf;
	wire pin_request;
	wire pin_same;
	wire pin_commit;
	wire [GAIN_W-1:0] gain_limit;
	wire [GAIN_W-1:0] gain_eff;
	wire [GAIN_W-1:0] new_gain;
	wire [STAGE_W-1:0] next_coarse;
	wire [STAGE_W-1:0] next_fine;
	wire [GAIN_W-1:0] coarse_span;
	wire [SAMPLE_W-1:0] next_sample;
	wire [DATA_W-1:0] next_rdata;

	assign wr_lpf = reg_wr && (reg_addr == LPF_CTRL_OFS);
	assign wr_tune = reg_wr && (reg_addr == TUNE_OFS);
	assign wr_gain = reg_wr && (reg_addr == GAIN_OFS);
	assign wr_hpf = reg_wr && (reg_addr == HPF_CTRL_OFS);

	// Pins program gain only with gain high and sync low
	assign pin_request = gain_pin_sync[SYNC_STAGES-1] &&
		!tx_sync_sync[SYNC_STAGES-1];
	assign pin_same = (gain_val_sync == held_val);
	assign pin_commit = (pin_state == PIN_HOLD) && pin_request &&
		pin_same && (hold_cnt == 2'(GAIN_PIN_HOLD - 1));

	// Register port wins if both land in one cycle
	assign new_gain = wr_gain ? reg_wdata[GAIN_W-1:0] : held_val;

	// Wide band caps the total at +30 dB
	assign gain_limit = lpf_wide ? GAIN_MAX_WIDE : GAIN_MAX_NARROW;
	assign gain_eff = (gain_setting > gain_limit) ? gain_limit :
		gain_setting;

	// Coarse takes whole 6 dB steps, fine takes the remainder in 2 dB steps
	assign next_coarse = (gain_eff >= 5'(COARSE_MAX) * FINE_STEPS) ?
		COARSE_MAX : 3'(gain_eff / FINE_STEPS);
	assign coarse_span = 5'(next_coarse) * FINE_STEPS;
	assign next_fine = 3'(gain_eff - coarse_span);

	// Bypass drops the filter's register from the path
	assign next_sample = hpf_bypass ? adc_sample :
		filt_sample;

	assign next_rdata =
		(reg_addr == LPF_CTRL_OFS) ? lpf_ctrl :
		(reg_addr == TUNE_OFS) ? tune_target :
		(reg_addr == GAIN_OFS) ? 8'(gain_setting) :
		(reg_addr == HPF_CTRL_OFS) ? 8'(hpf_bypass) :
		(reg_addr == STATUS_OFS) ? {2'h0, coarse_gain_stage,
			fine_gain_stage} :
		8'h00;

	hpf_core u_hpf (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.in_sample(adc_sample),
		.out_sample(filt_sample)
	);

	// Pins cross from the transmit clock; first stage feeds only the second
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			gain_pin_sync <= '0;
			tx_sync_sync <= '0;
			gain_val_meta <= '0;
			gain_val_sync <= '0;
		end
		else
		begin
			gain_pin_sync <= {gain_pin_sync[0], gain_pin};
			tx_sync_sync <= {tx_sync_sync[0], tx_sync_pin};
			gain_val_meta <= tx_gain_pins;
			gain_val_sync <= gain_val_meta;
		end
	end

	// Gain value must stand for three clocks before it is taken
	always_comb
	begin
		next_pin_state = pin_state;
		unique case (pin_state)
			PIN_IDLE:
				if (pin_request)
					next_pin_state = PIN_HOLD;
			PIN_HOLD:
				if (!pin_request)
					next_pin_state = PIN_IDLE;
				else if (pin_commit)
					next_pin_state = PIN_DONE;
			PIN_DONE:
				if (!pin_request)
					next_pin_state = PIN_IDLE;
				else if (!pin_same)
					next_pin_state = PIN_HOLD;
			default:
				next_pin_state = PIN_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_state <= PIN_IDLE;
			hold_cnt <= '0;
			held_val <= '0;
		end
		else
		begin
			pin_state <= next_pin_state;
			held_val <= gain_val_sync;
			if (!pin_request || !pin_same || pin_state != PIN_HOLD)
				hold_cnt <= '0;
			else if (!pin_commit)
				hold_cnt <= hold_cnt + 2'h1;
		end
	end

	// Control registers
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lpf_ctrl <= LPF_CTRL_RST;
			tune_target <= TUNE_RST;
			gain_setting <= GAIN_RST;
			hpf_bypass <= HPF_BYPASS_RST;
		end
		else
		begin
			if (wr_lpf)
				lpf_ctrl <= reg_wdata;
			if (wr_tune)
				tune_target <= reg_wdata;
			if (wr_gain || pin_commit)
				gain_setting <= new_gain;
			if (wr_hpf)
				hpf_bypass <= reg_wdata[HPF_BYPASS_BIT];
		end
	end

	// Analog controls follow their registers one clock later
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lpf_bypass <= LPF_CTRL_RST[LPF_BYPASS_BIT];
			lpf_wide <= LPF_CTRL_RST[LPF_WIDE_BIT];
			lpf_tune_target <= TUNE_RST;
			coarse_gain_stage <= '0;
			fine_gain_stage <= '0;
		end
		else
		begin
			lpf_bypass <= lpf_ctrl[LPF_BYPASS_BIT];
			lpf_wide <= lpf_ctrl[LPF_WIDE_BIT];
			lpf_tune_target <= tune_target;
			coarse_gain_stage <= next_coarse;
			fine_gain_stage <= next_fine;
		end
	end

	// Tags each output sample with the gain it carries; the analog
	// pipeline makes a fine-stage change visible seven clocks on
	generate
		for (genvar i = 0; i < GAIN_LATENCY; i++)
		begin : g_gain_pipe
			always_ff @(posedge ref_clk or posedge sys_rst)
			begin
				if (sys_rst)
					gain_pipe[i] <= '0;
				else if (i == 0)
					gain_pipe[i] <= gain_eff;
				else
					gain_pipe[i] <= gain_pipe[(i == 0) ? 0 : i - 1];
			end
		end
	endgenerate

	// Outputs
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_sample <= '0;
			sample_gain <= '0;
			reg_rdata <= '0;
		end
		else
		begin
			rx_sample <= next_sample;
			sample_gain <= gain_pipe[GAIN_LATENCY-2];
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
		end
	end
endmodule
`default_nettype wire

// File: shared/rx_path_pkg.sv
// Overview of operation
// - Single-pole IIR high-pass, zero 0.99994, pole 0.98466, one update per clock.
// - High-pass corner sits near one four-hundredth of the sample rate.
// - Filtered samples arrive exactly one clock later than bypassed ones.
// - A bypass control passes samples unfiltered and drops the extra clock.
// - Output samples are two's complement: 011..11 max, 100..00 min.
// - Out-of-range results clamp to the extreme codes, never wrap.
// - Gain spans -6 to +36 dB, or -6 to +30 dB in wide band.
// - Gain splits into coarse -6..24 dB and fine 0..12 dB in 2 dB.
// - New gain from register port or pins applies at once, unstaged.
// - A fine-only gain change shows in samples seven clocks later.
// - Bit 0 of register 4 bypasses the analog low-pass filter.
// - Register 5 holds the unsigned low-pass tuning target.
// - Register 6 bits 4:0 hold gain, written by port or pins.
package rx_path_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int SAMPLE_W = 10;
	localparam int GAIN_W = 5;
	localparam int STAGE_W = 3;
	localparam int FRAC_W = 16;
	localparam int ACC_W = 32;

	// Register indices
	localparam logic [4:0] LPF_CTRL_OFS = 5'h04;
	localparam logic [4:0] TUNE_OFS = 5'h05;
	localparam logic [4:0] GAIN_OFS = 5'h06;
	localparam logic [4:0] HPF_CTRL_OFS = 5'h0A;
	localparam logic [4:0] STATUS_OFS = 5'h0B;

	// Field positions
	localparam int LPF_BYPASS_BIT = 0;
	localparam int LPF_WIDE_BIT = 1;
	localparam int HPF_BYPASS_BIT = 0;

	// Reset values
	localparam logic [7:0] LPF_CTRL_RST = 8'h00;
	localparam logic [7:0] TUNE_RST = 8'h00;
	localparam logic [4:0] GAIN_RST = 5'h00;
	localparam logic HPF_BYPASS_RST = 1'b0;

	// Coefficients in Q16: 0.99994 and 0.98466 scaled by 65536
	localparam logic [16:0] ZERO_Q = 17'h0FFFC;
	localparam logic [16:0] POLE_Q = 17'h0FC13;

	// Gain index n means (2n - 6) dB total
	localparam logic [4:0] GAIN_MAX_NARROW = 5'h15;
	localparam logic [4:0] GAIN_MAX_WIDE = 5'h12;
	localparam logic [4:0] FINE_STEPS = 5'h03;
	localparam logic [2:0] COARSE_MAX = 3'h5;

	// Timing counts in ADC clocks
	localparam int GAIN_PIN_HOLD = 3;
	localparam int GAIN_LATENCY = 7;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		PIN_IDLE = 3'b001,
		PIN_HOLD = 3'b010,
		PIN_DONE = 3'b100
	} pin_state_t;
endpackage

// File: verif/adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_model
	import rx_path_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Input level, already saturated to codes by the caller
	input wire logic [rx_path_pkg::SAMPLE_W-1:0] level,
	// Converted sample
	output logic [rx_path_pkg::SAMPLE_W-1:0] adc_sample
);
	// One conversion per ref_clk; 10 MHz is far under the 10-bit limit
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			adc_sample <= '0;
		else
			adc_sample <= level;
endmodule
`default_nettype wire

// File: verif/rx_dc_block_and_gain_path_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rx_path_checker
	import rx_path_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [rx_path_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rx_path_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [rx_path_pkg::DATA_W-1:0] reg_rdata,
	// Samples and controls
	input wire logic [rx_path_pkg::SAMPLE_W-1:0] adc_sample,
	input wire logic [rx_path_pkg::SAMPLE_W-1:0] rx_sample,
	input wire logic lpf_bypass,
	input wire logic lpf_wide,
	input wire logic [rx_path_pkg::DATA_W-1:0] lpf_tune_target,
	input wire logic [rx_path_pkg::STAGE_W-1:0] coarse_gain_stage,
	input wire logic [rx_path_pkg::STAGE_W-1:0] fine_gain_stage,
	input wire logic [rx_path_pkg::GAIN_W-1:0] sample_gain
);
	logic hpf_off;
	wire logic gain_wr;
	wire logic gain_rd;
	// Only unclamped narrow-band writes give an exact expected gain
	assign gain_wr = reg_wr && reg_addr == GAIN_OFS && !lpf_wide
		&& reg_wdata[4:0] <= GAIN_MAX_NARROW;
	assign gain_rd = reg_rd && reg_addr == GAIN_OFS;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			hpf_off <= HPF_BYPASS_RST;
		else if (reg_wr && reg_addr == HPF_CTRL_OFS)
			hpf_off <= reg_wdata[HPF_BYPASS_BIT];
	function automatic logic [2:0] coarse_of(input logic [4:0] n);
		return (n > 5'h11) ? COARSE_MAX : 3'(n / 5'h03);
	endfunction
	a_byp_latency: assert property (
		hpf_off [*3] |-> rx_sample == $past(adc_sample))
		else $error("bypassed sample not one cycle late");
	a_lpf_byp_copy: assert property (
		reg_wr && reg_addr == LPF_CTRL_OFS |->
		##2 lpf_bypass == $past(reg_wdata[LPF_BYPASS_BIT], 2))
		else $error("low-pass bypass not taken from write");
	a_tune_copy: assert property (
		reg_wr && reg_addr == TUNE_OFS |->
		##2 lpf_tune_target == $past(reg_wdata, 2))
		else $error("tuning target not taken from write");
	a_gain_split: assert property (
		gain_wr |-> ##2 coarse_gain_stage == coarse_of($past(reg_wdata[4:0], 2))
		&& fine_gain_stage == 3'($past(reg_wdata[4:0], 2)
		- 5'(3 * coarse_of($past(reg_wdata[4:0], 2)))))
		else $error("gain split wrong");
	a_gain_seven: assert property (
		gain_wr ##1 !(reg_wr && reg_addr == GAIN_OFS) [*7] |=>
		sample_gain == $past(reg_wdata[4:0], 8))
		else $error("sample gain not seven clocks after register");
	a_gain_range: assert property (
		5'(3 * coarse_gain_stage) + 5'(fine_gain_stage) <= GAIN_MAX_NARROW
		&& sample_gain <= GAIN_MAX_NARROW)
		else $error("gain beyond range");
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_gain_readback: assert property (
		gain_wr ##1 !reg_wr ##1 gain_rd |=>
		reg_rdata == {3'h0, $past(reg_wdata[4:0], 3)})
		else $error("gain readback wrong");
	c_byp: cover property (hpf_off [*3]);
	c_gain: cover property (gain_wr);
	c_clamp: cover property (rx_sample == 10'h1FF);
endmodule
bind rx_dc_block_and_gain_path rx_path_checker rx_path_checker_i (.ref_clk,
	.sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_sample,
	.rx_sample, .lpf_bypass, .lpf_wide, .lpf_tune_target, .coarse_gain_stage,
	.fine_gain_stage, .sample_gain);
`default_nettype wire

// File: verif/rx_dc_block_and_gain_path_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rx_dc_block_and_gain_path_tb;
	import rx_path_pkg::*;
	logic ref_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic gain_pin = 1'h0;
	logic tx_sync_pin = 1'h0;
	logic [GAIN_W-1:0] tx_gain_pins = '0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic [SAMPLE_W-1:0] level = '0;
	logic [SAMPLE_W-1:0] adc_sample, rx_sample;
	logic [DATA_W-1:0] reg_rdata, lpf_tune_target;
	logic [STAGE_W-1:0] coarse_gain_stage, fine_gain_stage;
	logic [GAIN_W-1:0] sample_gain;
	logic lpf_bypass, lpf_wide;
	int failures = 0;
	int num_checks = 0;
	int k;
	always #50 ref_clk = ~ref_clk;
	adc_model adc_model_i (.ref_clk, .sys_rst, .level, .adc_sample);
	rx_dc_block_and_gain_path rx_dc_block_and_gain_path_i (.ref_clk, .sys_rst,
		.adc_sample, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.gain_pin, .tx_sync_pin, .tx_gain_pins, .rx_sample, .lpf_bypass,
		.lpf_wide, .lpf_tune_target, .coarse_gain_stage, .fine_gain_stage,
		.sample_gain);
	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want)
		begin
			failures++;
			$display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] want);
		@(posedge ref_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1;
		check(reg_rdata, want);
	endtask
	function automatic logic [31:0] probe(input int sel);
		return (sel == 0) ? 32'(rx_sample) : (sel == 1) ? 32'(sample_gain)
			: 32'(coarse_gain_stage);
	endfunction
	// Counts edges until the probed output shows v; gives up after 12
	task automatic wait_val(input int sel, input logic [31:0] v);
		k = 0;
		do
		begin
			tick(1);
			k++;
			if (k > 12)
			begin
				failures++;
				$display("CHECK FAILED at %0t: wait ran out", $time);
				test_done();
			end
		end
		while (probe(sel) !== v);
	endtask
	task automatic impulse(input logic [SAMPLE_W-1:0] v);
		@(posedge ref_clk);
		level <= v;
		@(posedge ref_clk);
		level <= '0;
		#1;
		wait_val(0, 32'(v));
	endtask
	task automatic t_regs();
		wr(LPF_CTRL_OFS, 8'h01);
		tick(1);
		check({lpf_bypass, lpf_wide}, 2'h2);
		wr(TUNE_OFS, 8'hA5);
		tick(1);
		check(lpf_tune_target, 8'hA5);
		rd_chk(TUNE_OFS, 8'hA5);
		rd_chk(5'h1F, 8'h00);
	endtask
	task automatic t_gain();
		logic [4:0] gv[6] = '{5'h05, 5'h15, 5'h00, 5'h19, 5'h09, 5'h14};
		logic [4:0] lim;
		logic [4:0] n;
		logic [2:0] c;
		for (int i = 0; i < 6; i++)
		begin
			lim = (i == 5) ? GAIN_MAX_WIDE : GAIN_MAX_NARROW;
			wr(LPF_CTRL_OFS, (i == 5) ? 8'h02 : 8'h00);
			n = (gv[i] > lim) ? lim : gv[i];
			c = (n > 5'h11) ? 3'h5 : 3'(n / 5'h03);
			wr(GAIN_OFS, {3'h0, gv[i]});
			rd_chk(GAIN_OFS, {3'h0, gv[i]});
			// The read took two of the seven clocks
			wait_val(1, 32'(n));
			check(k, 5);
			check({coarse_gain_stage, fine_gain_stage}, {c, 3'(n - 5'(3 * c))});
			rd_chk(STATUS_OFS, {2'h0, c, 3'(n - 5'(3 * c))});
		end
	endtask
	task automatic t_pins();
		wr(LPF_CTRL_OFS, 8'h00);
		@(posedge ref_clk);
		gain_pin <= 1'h1;
		tx_sync_pin <= 1'h1;
		tx_gain_pins <= 5'h09;
		tick(12);
		rd_chk(GAIN_OFS, 8'h14);
		@(posedge ref_clk);
		tx_sync_pin <= 1'h0;
		wait_val(2, 32'h3);
		rd_chk(GAIN_OFS, 8'h09);
		@(posedge ref_clk);
		gain_pin <= 1'h0;
	endtask
	// Full-scale steps overshoot the filter to about twice full scale
	task automatic t_clamp();
		@(posedge ref_clk);
		level <= 10'h200;
		tick(600);
		check($signed(rx_sample) >= -4 && $signed(rx_sample) <= 0, 1'h1);
		@(posedge ref_clk);
		level <= 10'h1FF;
		wait_val(0, 32'h1FF);
		check(rx_sample ^ 10'h200, 10'h3FF);
		tick(600);
		@(posedge ref_clk);
		level <= 10'h200;
		wait_val(0, 32'h200);
		check(rx_sample ^ 10'h200, 10'h000);
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'h0;
		tick(1);
		check({rx_sample, sample_gain, coarse_gain_stage, lpf_bypass}, 0);
		rd_chk(GAIN_OFS, 8'h00);
		t_regs();
		t_gain();
		t_pins();
		t_clamp();
		@(posedge ref_clk);
		sys_rst <= 1'h1;
		level <= '0;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'h0;
		impulse(10'h064);
		check(k, 2);
		tick(1);
		check(rx_sample inside {10'h3FF, 10'h3FE}, 1'h1);
		wr(HPF_CTRL_OFS, 8'h01);
		rd_chk(HPF_CTRL_OFS, 8'h01);
		tick(3);
		impulse(10'h04D);
		check(k, 1);
		test_done();
	end
endmodule
`default_nettype wire
